// ---- sim/sap_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sap_conv_model (
	// Converter control
	input wire logic conv_clk,
	input wire logic conv_start_n,
	input wire logic [sap_pkg::NUM_CONV-1:0] buffer_enable_lines,
	// Converter outputs
	output logic status_line,
	output logic [sap_pkg::RES_W-1:0] res
);
	import sap_pkg::*;
	logic [RES_W-1:0] sar [NUM_CONV];
	logic [RES_W-1:0] val;
	int step = 11;
	initial res = 10'h000;
	// One sequencer serves all converters, since they share one start.
	always @(negedge conv_clk or negedge conv_start_n) begin
		for (int i = 0; i < NUM_CONV; i++) begin
			val = 10'h155 + 10'(i) * 10'h07B;
			// An unknown start level before reset must not look like a start pulse.
			if (conv_start_n === 1'b0) begin
				sar[i] = 10'h200;
			end else if (step < 10) begin
				sar[i][9 - step] = val[9 - step];
				if (step < 9) begin
					sar[i][8 - step] = 1'b1;
				end
			end
		end
		step = (conv_start_n === 1'b0) ? 0 : (step < 11 ? step + 1 : 11);
	end
	assign status_line = (step == 11);
	// A released bus shows the inverse of its last value, never a stale copy.
	always @(buffer_enable_lines) begin
		res = ~res;
		for (int i = 0; i < NUM_CONV; i++) begin
			if (buffer_enable_lines[i]) begin
				res = sar[i];
			end
		end
	end
endmodule
`default_nettype wire

// ---- sim/sap_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module sap_ctrl_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [sap_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sap_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [sap_pkg::DATA_W-1:0] reg_rdata,
	// Converter side
	input wire logic conv_clk,
	input wire logic conv_start_n,
	input wire logic [sap_pkg::NUM_CONV-1:0] buffer_enable_lines,
	input wire logic status_capture_input
);
	import sap_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Cycles since the converter clock last changed, saturating.
	logic [6:0] half_cnt_q;
	always_ff @(posedge sys_clk) begin
		if (rst || $changed(conv_clk)) begin
			half_cnt_q <= 7'h00;
		end else if (half_cnt_q != 7'h7F) begin
			half_cnt_q <= half_cnt_q + 7'h01;
		end
	end
	sequence start_pulse;
		(!conv_start_n)[*8] ##[1:280] conv_start_n;
	endsequence
	sequence enable_slot;
		$stable(buffer_enable_lines)[*4] ##1 (buffer_enable_lines == '0);
	endsequence
	// A half period under 46 cycles would push the converter past its top rate.
	clk_half_a: assert property ($changed(conv_clk) |-> ##46 $changed(conv_clk))
		else $error("converter clock half period wrong");
	clk_min_half_a: assert property ($changed(conv_clk) |-> half_cnt_q >= 7'h2D)
		else $error("converter clock half period too short");
	start_cause_a:
		assert property ($fell(conv_start_n) |-> $past(reg_wr && reg_addr == OFF_CTRL && reg_wdata[0]))
		else $error("start without go");
	start_edge_a: assert property ($rose(conv_start_n) |-> $rose(conv_clk))
		else $error("start released off clock edge");
	start_len_a: assert property ($fell(conv_start_n) |-> start_pulse)
		else $error("start pulse length wrong");
	one_enable_a: assert property ($onehot0(buffer_enable_lines))
		else $error("two enables high");
	enable_slot_a: assert property ($rose(|buffer_enable_lines) |=> enable_slot)
		else $error("enable slot wrong");
	enable_idle_a:
		assert property (|buffer_enable_lines |-> conv_start_n && status_capture_input)
		else $error("enable during conversion");
	busy_read_a:
		assert property (reg_rd && reg_addr == OFF_RESULT0 && !conv_start_n |=> reg_rdata == '0)
		else $error("result read while busy");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sap_ctrl sap_ctrl_assertions chk_i (
	.sys_clk(sys_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.conv_clk(conv_clk),
	.conv_start_n(conv_start_n),
	.buffer_enable_lines(buffer_enable_lines),
	.status_capture_input(status_capture_input)
);
`default_nettype wire

// ---- sim/tb_sar_adc_port_start_status_interface.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_port_start_status_interface;
	import sap_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ser_d = 1'b0, ser_t = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic [DATA_W-1:0] reg_rdata;
	logic irq, conv_clk, conv_start_n, status_line;
	logic [NUM_CONV-1:0] en;
	logic [RES_W-1:0] res;
	logic [RES_W-1:0] word = 10'h2B4;
	int fail_count = 0, compares = 0, n;
	always #10 sys_clk = ~sys_clk;
	sap_ctrl uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq(irq),
		.conv_clk(conv_clk),
		.conv_start_n(conv_start_n),
		.buffer_enable_lines(en),
		.status_capture_input(status_line),
		.result_low_port_lines(res[7:0]),
		.result_high_port_line_0(res[8]),
		.result_high_port_line_1(res[9]),
		.serial_data_in(ser_d),
		.serial_timing_in(ser_t)
	);
	sap_conv_model conv (
		.conv_clk(conv_clk),
		.conv_start_n(conv_start_n),
		.buffer_enable_lines(en),
		.status_line(status_line),
		.res(res)
	);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask
	task automatic summarize();
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Counts cycles in n so that the caller can judge the wait.
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq", 16'h0001, {15'h0000, irq});
		if (irq !== 1'b1) begin
			summarize();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(OFF_CTRL, 16'h0004, "ctrl");
		rd(OFF_STATUS, 16'h0002, "status");
		rd(4'hF, 16'h0000, "unmapped");
		wr(OFF_IRQ_MASK, 16'h0003);
		rd(OFF_IRQ_MASK, 16'h0003, "mask");
		wr(OFF_CTRL, 16'h0015);
		repeat (8) @(posedge sys_clk);
		rd(OFF_STATUS, 16'h0001, "busy");
		rd(OFF_RESULT0, 16'h0000, "busy_res");
		repeat (400) @(posedge sys_clk);
		wr(OFF_CTRL, 16'h0015);
		@(posedge sys_clk);
		chk("refused", 16'h0001, {15'h0000, conv_start_n});
		wait_irq();
		rd(OFF_IRQ_STAT, 16'h0001, "flag");
		rd(OFF_IRQ_STAT, 16'h0000, "flag_clr");
		for (int i = 0; i < NUM_CONV; i++) begin
			rd(OFF_RESULT0 + 4'(i), {6'h00, 10'h155 + 10'(i) * 10'h07B}, "res");
		end
		chk("irq_low", 16'h0000, {15'h0000, irq});
		wr(OFF_CTRL, 16'h0007);
		// Count from the release so a status-driven end would come too early.
		n = 0;
		while (conv_start_n !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		chk("release", 16'h0001, {15'h0000, conv_start_n});
		if (conv_start_n !== 1'b1) begin
			summarize();
		end
		wait_irq();
		chk("delay", 16'h0001, {15'h0000, n >= 1105});
		rd(OFF_RESULT0, 16'h0155, "res_delay");
		rd(OFF_IRQ_STAT, 16'h0000, "res_clr");
		wr(OFF_IRQ_MASK, 16'h0001);
		for (int b = 9; b >= 0; b--) begin
			ser_d <= word[b];
			repeat (4) @(posedge sys_clk);
			ser_t <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ser_t <= 1'b0;
		end
		repeat (6) @(posedge sys_clk);
		chk("masked", 16'h0000, {15'h0000, irq});
		rd(OFF_SERIAL, {6'h00, word}, "serial");
		rd(OFF_IRQ_STAT, 16'h0002, "ser_flag");
		wr(OFF_CTRL, 16'h0000);
		rd(OFF_CTRL, 16'h0004, "nconv_min");
		wr(OFF_CTRL, 16'h001C);
		rd(OFF_CTRL, 16'h0014, "nconv_max");
		summarize();
	end
endmodule
`default_nettype wire

// ---- verilog/sap_ctrl.sv ----
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sap_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Software register port
	input wire logic [sap_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sap_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sap_pkg::DATA_W-1:0] reg_rdata,
	output logic irq,
	// Converter control
	output logic conv_clk,
	output logic conv_start_n,
	output logic [sap_pkg::NUM_CONV-1:0] buffer_enable_lines,
	// Converter outputs
	input wire logic status_capture_input,
	input wire logic [sap_pkg::LOW_W-1:0] result_low_port_lines,
	input wire logic result_high_port_line_0,
	input wire logic result_high_port_line_1,
	input wire logic serial_data_in,
	input wire logic serial_timing_in
);
	import sap_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	logic [RES_W+2:0] pins_s;
	logic status_s;
	logic ser_s;
	logic tim_s;
	logic [RES_W-1:0] result_s;

	sap_sync #(.W(RES_W + 3)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({serial_timing_in, serial_data_in, status_capture_input,
			result_high_port_line_1, result_high_port_line_0, result_low_port_lines}),
		.sync_out(pins_s)
	);

	// Ten bits arrive as eight low port lines plus two high lines.
	assign result_s = pins_s[RES_W-1:0];
	assign status_s = pins_s[RES_W];
	assign ser_s = pins_s[RES_W+1];
	assign tim_s = pins_s[RES_W+2];

	////////////////////////////////////////////////////////////////////////////

	sap_state_e state_q, state_d;
	logic [5:0] div_q, div_d;
	logic conv_clk_q, conv_clk_d;
	logic start_n_q, start_n_d;
	logic [1:0] edge_cnt_q, edge_cnt_d;
	logic [10:0] wait_q, wait_d;
	logic [2:0] settle_q, settle_d;
	logic [2:0] idx_q, idx_d;
	logic [NUM_CONV-1:0] ben_q, ben_d;
	logic [RES_W-1:0] res_q [NUM_CONV];
	logic [RES_W-1:0] res_d [NUM_CONV];
	logic status_prev_q, status_prev_d;
	logic tim_prev_q, tim_prev_d;
	logic [RES_W-1:0] ser_shift_q, ser_shift_d;
	logic [RES_W-1:0] ser_word_q, ser_word_d;
	logic [3:0] ser_cnt_q, ser_cnt_d;
	logic delay_mode_q, delay_mode_d;
	logic [2:0] nconv_q, nconv_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_mask_q, irq_mask_d;
	logic irq_q, irq_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;

	logic rise_tick;
	logic status_rise;
	logic tim_rise;
	logic [1:0] irq_set;
	logic [3:0] res_off;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_d = state_q;
		div_d = div_q;
		conv_clk_d = conv_clk_q;
		start_n_d = start_n_q;
		edge_cnt_d = edge_cnt_q;
		wait_d = wait_q;
		settle_d = settle_q;
		idx_d = idx_q;
		ben_d = ben_q;
		for (int i = 0; i < NUM_CONV; i++) begin
			res_d[i] = res_q[i];
		end
		status_prev_d = status_s;
		tim_prev_d = tim_s;
		ser_shift_d = ser_shift_q;
		ser_word_d = ser_word_q;
		ser_cnt_d = ser_cnt_q;
		delay_mode_d = delay_mode_q;
		nconv_d = nconv_q;
		irq_mask_d = irq_mask_q;
		rdata_d = '0;
		irq_set = '0;
		res_off = reg_addr - OFF_RESULT0;

		// The converter clock is a divided copy of the system clock.
		rise_tick = (div_q == CONV_HALF_M1) && !conv_clk_q;
		if (div_q == CONV_HALF_M1) begin
			div_d = '0;
			conv_clk_d = !conv_clk_q;
		end else begin
			div_d = div_q + 6'h01;
		end

		// A rising edge of the shared status line means every converter is done.
		status_rise = status_s && !status_prev_q;
		tim_rise = tim_s && !tim_prev_q;

		// One serial bit per rising edge of the timing pulse.
		if (tim_rise) begin
			ser_shift_d = {ser_shift_q[RES_W-2:0], ser_s};
			if (ser_cnt_q == 4'(RES_W - 1)) begin
				ser_cnt_d = '0;
				ser_word_d = {ser_shift_q[RES_W-2:0], ser_s};
				irq_set[IRQ_SER_BIT] = 1'b1;
			end else begin
				ser_cnt_d = ser_cnt_q + 4'h1;
			end
		end

		case (state_q)
			SAP_IDLE: begin
				// A start is refused while the status line still reads busy.
				if (reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_GO_BIT] && status_s) begin
					state_d = SAP_START_LOW;
					start_n_d = 1'b0;
					edge_cnt_d = '0;
					ser_cnt_d = '0;
				end
			end
			SAP_START_LOW: begin
				// Start held low for whole converter periods; the reset code is held meanwhile.
				start_n_d = 1'b0;
				if (rise_tick) begin
					edge_cnt_d = edge_cnt_q + 2'h1;
					if (edge_cnt_q == START_LOW_EDGES - 2'h1) begin
						state_d = SAP_WAIT_REL;
					end
				end
			end
			SAP_WAIT_REL: begin
				// Release only on a converter clock rising edge, like the retiming flop.
				if (rise_tick) begin
					start_n_d = 1'b1;
					wait_d = DELAY_CNT;
					state_d = SAP_CONVERT;
				end
			end
			SAP_CONVERT: begin
				// Delay mode outlasts eleven falling edges and the conversion time.
				if (delay_mode_q) begin
					if (wait_q == 11'h000) begin
						state_d = SAP_READ_EN;
					end else begin
						wait_d = wait_q - 11'h001;
					end
				end else if (status_rise) begin
					state_d = SAP_READ_EN;
				end
				idx_d = '0;
				settle_d = SETTLE_CYC;
			end
			SAP_READ_EN: begin
				// Exactly one enable at a time, converters in turn.
				ben_d = sap_onehot(idx_q);
				if (settle_q == 3'h0) begin
					state_d = SAP_READ_CAP;
				end else begin
					settle_d = settle_q - 3'h1;
				end
			end
			SAP_READ_CAP: begin
				res_d[idx_q] = result_s;
				// All enables drop for a cycle before the next one rises.
				ben_d = '0;
				settle_d = SETTLE_CYC;
				if (idx_q == nconv_q - 3'h1) begin
					state_d = SAP_IDLE;
					irq_set[IRQ_DONE_BIT] = 1'b1;
				end else begin
					idx_d = idx_q + 3'h1;
					state_d = SAP_READ_EN;
				end
			end
			default: begin
				state_d = SAP_IDLE;
				start_n_d = 1'b1;
				ben_d = '0;
			end
		endcase

		// Delay mode and converter count are written only while idle so a run never changes shape; the mask at any time.
		if (reg_wr && state_q == SAP_IDLE && reg_addr == OFF_CTRL) begin
			delay_mode_d = reg_wdata[CTRL_DELAY_BIT];
			nconv_d = sap_clamp_nconv(reg_wdata[CTRL_NCONV_LSB +: 3]);
		end
		if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
			irq_mask_d = reg_wdata[1:0];
		end

		// Read clears; a flag set in the same cycle survives.
		irq_stat_d = irq_stat_q;
		if (reg_rd && reg_addr == OFF_IRQ_STAT) begin
			irq_stat_d = '0;
		end
		// Reading the first result word also clears completion.
		if (reg_rd && reg_addr == OFF_RESULT0) begin
			irq_stat_d[IRQ_DONE_BIT] = 1'b0;
		end
		irq_stat_d = irq_stat_d | irq_set;

		// Either flag, completion or serial word, drives the interrupt line directly when unmasked.
		irq_d = |(irq_stat_d & irq_mask_d);

		if (reg_rd) begin
			if (reg_addr == OFF_CTRL) begin
				rdata_d[CTRL_DELAY_BIT] = delay_mode_q;
				rdata_d[CTRL_NCONV_LSB +: 3] = nconv_q;
			end else if (reg_addr == OFF_STATUS) begin
				rdata_d[STAT_BUSY_BIT] = (state_q != SAP_IDLE);
				rdata_d[STAT_LINE_BIT] = status_s;
			end else if (reg_addr == OFF_IRQ_STAT) begin
				rdata_d[1:0] = irq_stat_q;
			end else if (reg_addr == OFF_IRQ_MASK) begin
				rdata_d[1:0] = irq_mask_q;
			end else if (reg_addr >= OFF_RESULT0 && res_off < 4'(NUM_CONV)) begin
				// Results read during a run would be stale, so busy reads zero.
				if (state_q == SAP_IDLE) begin
					rdata_d[RES_W-1:0] = res_q[res_off[2:0]];
				end
			end else if (reg_addr == OFF_SERIAL) begin
				rdata_d[RES_W-1:0] = ser_word_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= SAP_IDLE;
			div_q <= '0;
			conv_clk_q <= 1'b0;
			start_n_q <= 1'b1;
			edge_cnt_q <= '0;
			wait_q <= '0;
			settle_q <= '0;
			idx_q <= '0;
			ben_q <= '0;
			for (int i = 0; i < NUM_CONV; i++) begin
				res_q[i] <= '0;
			end
			status_prev_q <= 1'b0;
			tim_prev_q <= 1'b0;
			ser_shift_q <= '0;
			ser_word_q <= '0;
			ser_cnt_q <= '0;
			delay_mode_q <= CTRL_DELAY_RST;
			nconv_q <= CTRL_NCONV_RST;
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			conv_clk_q <= conv_clk_d;
			start_n_q <= start_n_d;
			edge_cnt_q <= edge_cnt_d;
			wait_q <= wait_d;
			settle_q <= settle_d;
			idx_q <= idx_d;
			ben_q <= ben_d;
			for (int i = 0; i < NUM_CONV; i++) begin
				res_q[i] <= res_d[i];
			end
			status_prev_q <= status_prev_d;
			tim_prev_q <= tim_prev_d;
			ser_shift_q <= ser_shift_d;
			ser_word_q <= ser_word_d;
			ser_cnt_q <= ser_cnt_d;
			delay_mode_q <= delay_mode_d;
			nconv_q <= nconv_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign conv_clk = conv_clk_q;
	assign conv_start_n = start_n_q;
	assign buffer_enable_lines = ben_q;

endmodule
`default_nettype wire

// ---- verilog/sap_pkg.sv ----
package sap_pkg;

	localparam int SYS_CLK_KHZ = 50000;
	localparam int CONV_CLK_MAX_KHZ = 550;
	localparam int CONV_HALF = (SYS_CLK_KHZ + 2 * CONV_CLK_MAX_KHZ - 1) / (2 * CONV_CLK_MAX_KHZ);
	localparam logic [5:0] CONV_HALF_M1 = 6'(CONV_HALF - 1);
	localparam int CONV_TIME_US = 20;
	localparam int CONV_TIME_CYC = CONV_TIME_US * SYS_CLK_KHZ / 1000;
	localparam int CONV_EDGES = 12;
	localparam int EDGE_CYC = CONV_EDGES * 2 * CONV_HALF;
	localparam int DELAY_CYC = (EDGE_CYC > CONV_TIME_CYC) ? EDGE_CYC : CONV_TIME_CYC;
	localparam logic [10:0] DELAY_CNT = 11'(DELAY_CYC);
	localparam logic [1:0] START_LOW_EDGES = 2'h2;
	localparam logic [2:0] SETTLE_CYC = 3'h4;

	localparam int NUM_CONV = 5;
	localparam int RES_W = 10;
	localparam int LOW_W = 8;
	localparam int HIGH_W = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h1;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h2;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
	localparam logic [3:0] OFF_RESULT0 = 4'h4;
	localparam logic [3:0] OFF_SERIAL = 4'h9;

	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_DELAY_BIT = 1;
	localparam int CTRL_NCONV_LSB = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LINE_BIT = 1;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SER_BIT = 1;

	localparam logic CTRL_DELAY_RST = 1'b0;
	localparam logic [2:0] CTRL_NCONV_RST = 3'h1;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;

	typedef enum logic [5:0] {
		SAP_IDLE = 6'h01,
		SAP_START_LOW = 6'h02,
		SAP_WAIT_REL = 6'h04,
		SAP_CONVERT = 6'h08,
		SAP_READ_EN = 6'h10,
		SAP_READ_CAP = 6'h20
	} sap_state_e;

	function automatic logic [NUM_CONV-1:0] sap_onehot(input logic [2:0] idx);
		logic [NUM_CONV-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction

	function automatic logic [2:0] sap_clamp_nconv(input logic [2:0] n);
		logic [2:0] r;
		r = n;
		if (n == 3'h0) begin
			r = 3'h1;
		end else if (n > 3'(NUM_CONV)) begin
			r = 3'(NUM_CONV);
		end
		return r;
	endfunction

endpackage

// ---- verilog/sap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sap_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Asynchronous level in, synchronised level out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage feeds only the second stage, never logic.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule
`default_nettype wire
